// File: sps_checker.sv
// Purpose: port assertions for the set-point sequencer
// Assumes: ce high across bus transfers and reset
// Notes:   one-second ramp timing is too slow to watch here
`default_nettype none
module sps_checker (
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        ce,
    input wire logic        is_controller,
    // write channels
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    // read channels
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // set point and storage request
    input wire logic [15:0] program_setpoint,
    input wire logic        nv_write
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    reset_clear_a: assert property (!$past(aresetn) |-> program_setpoint == 16'h0 && !nv_write && !s_axi_bvalid)
        else $error("outputs not cleared by reset");
    idle_hold_a: assert property (!is_controller && !$past(is_controller) && !$past(is_controller, 2)
        |-> $stable(program_setpoint)) else $error("set point moved in monitor function");
    freeze_hold_a: assert property (!$past(ce) |-> $stable(program_setpoint) && $stable(s_axi_bvalid)
        && $stable(s_axi_rvalid)) else $error("state moved while clock enable low");
    nv_cause_a: assert property (nv_write |-> s_axi_bvalid || $past(s_axi_bvalid))
        else $error("storage request without a write response");
    nv_pulse_a: assert property (nv_write && ce |=> !nv_write)
        else $error("storage request longer than one cycle");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
    wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid) else $error("write response late");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
        else $error("read data late");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("address taken while read data pending");
endmodule
bind sps_top sps_checker chk_u (.aclk, .aresetn, .ce, .is_controller, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .program_setpoint, .nv_write);
`default_nettype wire

// File: sps_flow_partner.sv
// Purpose: stand-in for the mated flow controller taking the set point
// Assumes: set point in tenths of a percent of full scale
// Notes:   logs each new set point so step order can be judged
`default_nettype none
module sps_flow_partner
    import sps_pkg::*;
(
    // clock and reset
    input wire logic            aclk,
    input wire logic            aresetn,
    // set point from the sequencer
    input wire logic [SP_W-1:0] program_setpoint
);
    logic [SP_W-1:0] seen[$];
    logic [SP_W-1:0] last_sp = 16'h0000;
    // only changes are kept, a held point would flood the log
    always @(posedge aclk) begin
        if (aresetn && program_setpoint !== last_sp) begin
            seen.push_back(program_setpoint);
            last_sp = program_setpoint;
        end
    end
endmodule
`default_nettype wire

// File: sps_next_step.sv
// Purpose: find the next unmasked step at or after a start index
// Assumes: combinational, sixteen steps
// Notes:   found is low when no enabled step lies ahead
`default_nettype none
module sps_next_step
    import sps_pkg::*;
(
    // search
    input  wire logic [STEPS-1:0] mask,
    input  wire logic [4:0]       from_idx,
    // result
    output logic                  found,
    output logic [3:0]            idx
);
    always_comb begin
        found = 1'b0;
        idx   = 4'h0;
        for (int i = STEPS - 1; i >= 0; i--) begin
            if (mask[i] && (5'(i) >= from_idx)) begin
                found = 1'b1;
                idx   = 4'(i);
            end
        end
    end
endmodule
`default_nettype wire

// File: sps_pkg.sv
// Purpose: shared constants and types for the set-point program sequencer
// Assumes: 32-bit axi4-lite register bus, 40 MHz aclk
// Notes:   set point is tenths of a percent of full scale (0..1000)
`default_nettype none
package sps_pkg;
    localparam int unsigned STEPS        = 16;
    localparam int unsigned SP_W         = 16;
    localparam int unsigned TIME_W       = 16;
    localparam int unsigned CLK_HZ       = 40000000;
    localparam int unsigned SEC_S        = 1;
    localparam int unsigned SEC_CYCLES   = SEC_S * CLK_HZ;
    localparam logic [15:0] SP_FULL      = 16'h03e8;
    // register byte offsets
    localparam logic [7:0]  OFF_CTRL     = 8'h00;
    localparam logic [7:0]  OFF_MASK     = 8'h04;
    localparam logic [7:0]  OFF_STATUS   = 8'h08;
    localparam logic [7:0]  OFF_SETPOINT = 8'h0c;
    localparam logic [7:0]  OFF_NV_CNT   = 8'h10;
    localparam logic [7:0]  OFF_TABLE    = 8'h40;
    // control fields
    localparam int unsigned CTRL_EN      = 0;
    localparam int unsigned CTRL_LOOP    = 1;
    localparam int unsigned CTRL_PAUSE   = 2;
    localparam int unsigned CTRL_START   = 3;
    localparam logic [3:0]  CTRL_RESET   = 4'h0;
    localparam logic [15:0] MASK_RESET   = 16'hffff;
    localparam logic [1:0]  RESP_OKAY    = 2'b00;
    localparam logic [1:0]  RESP_SLVERR  = 2'b10;
    typedef enum logic [1:0] {SPS_IDLE, SPS_SEEK, SPS_RUN, SPS_DONE} sps_state_t;
endpackage
`default_nettype wire

// File: sps_ramp.sv
// Purpose: linear set-point ramp from a start value to a target over n seconds
// Assumes: load pulses once per step, tick pulses once per second
// Notes:   output is interpolated each second; zero seconds applies target at once
`default_nettype none
module sps_ramp
    import sps_pkg::*;
(
    // clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic              ce,
    // control
    input  wire logic              load,
    input  wire logic              tick,
    input  wire logic [SP_W-1:0]   start_sp,
    input  wire logic [SP_W-1:0]   target,
    input  wire logic [TIME_W-1:0] secs,
    // result
    output logic [SP_W-1:0]        sp,
    output logic                   done
);
    logic [TIME_W-1:0] el_reg, el_next;
    logic [TIME_W-1:0] dur_reg, dur_next;
    logic [SP_W-1:0]   st_reg, st_next, tg_reg, tg_next;
    logic signed [SP_W+TIME_W+1:0] diff;

    always_comb begin
        el_next  = el_reg;
        dur_next = dur_reg;
        st_next  = st_reg;
        tg_next  = tg_reg;
        if (load) begin
            el_next  = '0;
            dur_next = secs;
            st_next  = start_sp;
            tg_next  = target;
        end else if (tick && el_reg < dur_reg) begin
            el_next = el_reg + 16'h0001;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            el_reg  <= '0;
            dur_reg <= '0;
            st_reg  <= '0;
            tg_reg  <= '0;
        end else if (ce) begin
            el_reg  <= el_next;
            dur_reg <= dur_next;
            st_reg  <= st_next;
            tg_reg  <= tg_next;
        end
    end

    // start + (target - start) * elapsed / duration
    always_comb begin
        diff = (34'(signed'({1'b0, tg_reg})) - 34'(signed'({1'b0, st_reg}))) * 34'(signed'({1'b0, el_reg}));
        done = (el_reg >= dur_reg);
        if (done) begin
            sp = tg_reg;
        end else begin
            sp = SP_W'(34'(signed'({1'b0, st_reg})) + diff / 34'(signed'({1'b0, dur_reg})));
        end
    end
endmodule
`default_nettype wire

// File: sps_top.sv
// Purpose: stepped set-point program sequencer with axi4-lite registers
// Assumes: software copies table and mask to non-volatile storage on nv_write
// Notes:   set point units are tenths of percent of full scale
//
// Summary of operation
// - sixteen steps of target and seconds
// - set point ramps linearly over step time
// - runs only in controller function
// - global enable, reset disabled
// - loop wraps to first enabled step
// - masked steps are skipped
// - one mask bit per step, a set bit enables its step
// - all steps unmasked after reset
// - loop and pause accepted while running
// - mask changes flagged for non-volatile save
// - table changes flagged for non-volatile save
//
// Our own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`default_nettype none
module sps_top
    import sps_pkg::*;
(
    // clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             ce,
    // device function strap: high selects controller
    input  wire logic             is_controller,
    // axi4-lite write address
    input  wire logic [7:0]       s_axi_awaddr,
    input  wire logic             s_axi_awvalid,
    output logic                  s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]      s_axi_wdata,
    input  wire logic [3:0]       s_axi_wstrb,
    input  wire logic             s_axi_wvalid,
    output logic                  s_axi_wready,
    // axi4-lite write response
    output logic [1:0]            s_axi_bresp,
    output logic                  s_axi_bvalid,
    input  wire logic             s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]       s_axi_araddr,
    input  wire logic             s_axi_arvalid,
    output logic                  s_axi_arready,
    output logic [31:0]           s_axi_rdata,
    output logic [1:0]            s_axi_rresp,
    output logic                  s_axi_rvalid,
    input  wire logic             s_axi_rready,
    // set point to the mated controller and storage request
    output logic [SP_W-1:0]       program_setpoint,
    output logic                  nv_write
);
    import sps_pkg::*;

    // register state
    logic [3:0]        ctrl_reg, ctrl_next;
    logic [STEPS-1:0]  mask_reg, mask_next;
    logic [SP_W-1:0]   tgt_mem [STEPS];
    logic [TIME_W-1:0] sec_mem [STEPS];
    logic [15:0]       nvcnt_reg, nvcnt_next;
    logic              nv_reg, nv_next;
    // bus state
    logic              aw_reg, aw_next, w_reg, w_next, b_reg, b_next;
    logic [7:0]        awa_reg, awa_next;
    logic [31:0]       wd_reg, wd_next;
    logic [3:0]        ws_reg, ws_next;
    logic [1:0]        br_reg, br_next, rr_reg, rr_next;
    logic              r_reg, r_next;
    logic [31:0]       rd_reg, rd_next;
    // sequencer state
    sps_state_t        st_reg, st_next;
    logic [3:0]        idx_reg, idx_next;
    logic [25:0]       div_reg, div_next;
    logic [SP_W-1:0]   sp_reg, sp_next;
    logic              load;
    logic              tick;
    logic [4:0]        seek_from;
    logic              nx_found;
    logic [3:0]        nx_idx;
    logic [SP_W-1:0]   ramp_sp;
    logic              ramp_done;
    logic              do_write;
    logic              tbl_we;
    logic [3:0]        tbl_idx;
    logic [31:0]       tbl_word;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                old[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return old;
    endfunction

    function automatic logic is_table(input logic [7:0] a);
        return a >= OFF_TABLE && a < (OFF_TABLE + 8'h40);
    endfunction

    sps_next_step u_next (
        .mask     (mask_reg),
        .from_idx (seek_from),
        .found    (nx_found),
        .idx      (nx_idx)
    );

    sps_ramp u_ramp (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .ce       (ce),
        .load     (load),
        .tick     (tick),
        // step being entered, so a load never picks up the step being left
        .start_sp (sp_next),
        .target   (tgt_mem[idx_next]),
        .secs     (sec_mem[idx_next]),
        .sp       (ramp_sp),
        .done     (ramp_done)
    );

    // write channel: address and data taken in either order, answered after both
    assign do_write = aw_reg && w_reg && !b_reg;
    assign tbl_we   = do_write && is_table(awa_reg);
    assign tbl_idx  = awa_reg[5:2];
    assign tbl_word = merge({sec_mem[tbl_idx], tgt_mem[tbl_idx]}, wd_reg, ws_reg);

    always_comb begin
        aw_next   = aw_reg;
        w_next    = w_reg;
        b_next    = b_reg;
        awa_next  = awa_reg;
        wd_next   = wd_reg;
        ws_next   = ws_reg;
        br_next   = br_reg;
        ctrl_next = ctrl_reg;
        mask_next = mask_reg;
        nv_next   = 1'b0;
        nvcnt_next = nvcnt_reg;
        if (!aw_reg && s_axi_awvalid) begin
            aw_next  = 1'b1;
            awa_next = s_axi_awaddr;
        end
        if (!w_reg && s_axi_wvalid) begin
            w_next  = 1'b1;
            wd_next = s_axi_wdata;
            ws_next = s_axi_wstrb;
        end
        if (do_write) begin
            b_next  = 1'b1;
            br_next = RESP_OKAY;
            aw_next = 1'b0;
            w_next  = 1'b0;
            case ({awa_reg[7:2], 2'b00})
                OFF_CTRL: begin
                    ctrl_next = 4'(merge(32'(ctrl_reg), wd_reg, ws_reg));
                end
                OFF_MASK: begin
                    mask_next = 16'(merge(32'(mask_reg), wd_reg, ws_reg));
                    nv_next   = 1'b1;
                end
                default: begin
                    if (is_table(awa_reg)) begin
                        nv_next = 1'b1;
                    end else if (awa_reg != OFF_STATUS && awa_reg != OFF_SETPOINT && awa_reg != OFF_NV_CNT) begin
                        br_next = RESP_SLVERR;
                    end
                end
            endcase
        end
        if (b_reg && s_axi_bready) begin
            b_next = 1'b0;
        end
        if (nv_reg) begin
            nvcnt_next = nvcnt_reg + 16'h0001;
        end
        // start is a one-shot request bit; kept while done so a restart is seen
        if (st_reg == SPS_SEEK || st_reg == SPS_RUN) begin
            ctrl_next[CTRL_START] = 1'b0;
        end
    end

    // read channel
    always_comb begin
        r_next  = r_reg;
        rd_next = rd_reg;
        rr_next = rr_reg;
        if (r_reg && s_axi_rready) begin
            r_next = 1'b0;
        end else if (!r_reg && s_axi_arvalid) begin
            r_next  = 1'b1;
            rr_next = RESP_OKAY;
            rd_next = 32'h0000_0000;
            if (is_table(s_axi_araddr)) begin
                rd_next = {sec_mem[s_axi_araddr[5:2]], tgt_mem[s_axi_araddr[5:2]]};
            end else begin
                case ({s_axi_araddr[7:2], 2'b00})
                    OFF_CTRL:     rd_next = 32'(ctrl_reg);
                    OFF_MASK:     rd_next = 32'(mask_reg);
                    OFF_STATUS:   rd_next = {24'h000000, idx_reg, 2'b00, 2'(st_reg)};
                    OFF_SETPOINT: rd_next = 32'(sp_reg);
                    OFF_NV_CNT:   rd_next = 32'(nvcnt_reg);
                    default:      rr_next = RESP_SLVERR;
                endcase
            end
        end
    end

    // sequencer: pause freezes the ramp by withholding the seconds tick
    assign tick = (st_reg == SPS_RUN) && !ctrl_reg[CTRL_PAUSE] && (div_reg == 26'(SEC_CYCLES - 1));

    always_comb begin
        st_next   = st_reg;
        idx_next  = idx_reg;
        div_next  = div_reg;
        sp_next   = sp_reg;
        load      = 1'b0;
        seek_from = 5'h00;
        if (st_reg == SPS_SEEK) begin
            seek_from = 5'(idx_reg);
        end else if (st_reg == SPS_RUN) begin
            seek_from = 5'(idx_reg) + 5'h01;
        end
        if (!is_controller || !ctrl_reg[CTRL_EN]) begin
            st_next  = SPS_IDLE;
            div_next = '0;
        end else begin
            case (st_reg)
                SPS_IDLE: begin
                    if (ctrl_reg[CTRL_START]) begin
                        idx_next = 4'h0;
                        st_next  = SPS_SEEK;
                    end
                end
                SPS_SEEK: begin
                    if (nx_found) begin
                        idx_next = nx_idx;
                        st_next  = SPS_RUN;
                        load     = 1'b1;
                        div_next = '0;
                    end else begin
                        st_next = SPS_DONE;
                    end
                end
                SPS_RUN: begin
                    sp_next = ramp_sp;
                    if (!ctrl_reg[CTRL_PAUSE]) begin
                        div_next = (div_reg == 26'(SEC_CYCLES - 1)) ? 26'h0 : div_reg + 26'h1;
                    end
                    if (ramp_done && !ctrl_reg[CTRL_PAUSE]) begin
                        if (nx_found) begin
                            idx_next = nx_idx;
                            load     = 1'b1;
                            div_next = '0;
                        end else if (ctrl_reg[CTRL_LOOP]) begin
                            idx_next = 4'h0;
                            st_next  = SPS_SEEK;
                        end else begin
                            st_next = SPS_DONE;
                        end
                    end
                end
                SPS_DONE: begin
                    if (ctrl_reg[CTRL_START]) begin
                        idx_next = 4'h0;
                        st_next  = SPS_SEEK;
                    end
                end
                default: st_next = SPS_IDLE;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg  <= CTRL_RESET;
            mask_reg  <= MASK_RESET;
            nvcnt_reg <= '0;
            nv_reg    <= 1'b0;
            aw_reg    <= 1'b0;
            w_reg     <= 1'b0;
            b_reg     <= 1'b0;
            awa_reg   <= '0;
            wd_reg    <= '0;
            ws_reg    <= '0;
            br_reg    <= RESP_OKAY;
            r_reg     <= 1'b0;
            rd_reg    <= '0;
            rr_reg    <= RESP_OKAY;
            st_reg    <= SPS_IDLE;
            idx_reg   <= '0;
            div_reg   <= '0;
            sp_reg    <= '0;
        end else if (ce) begin
            ctrl_reg  <= ctrl_next;
            mask_reg  <= mask_next;
            nvcnt_reg <= nvcnt_next;
            nv_reg    <= nv_next;
            aw_reg    <= aw_next;
            w_reg     <= w_next;
            b_reg     <= b_next;
            awa_reg   <= awa_next;
            wd_reg    <= wd_next;
            ws_reg    <= ws_next;
            br_reg    <= br_next;
            r_reg     <= r_next;
            rd_reg    <= rd_next;
            rr_reg    <= rr_next;
            st_reg    <= st_next;
            idx_reg   <= idx_next;
            div_reg   <= div_next;
            sp_reg    <= sp_next;
        end
    end

    // program table: no reset, contents come from non-volatile storage
    always_ff @(posedge aclk) begin
        if (ce && tbl_we) begin
            tgt_mem[tbl_idx] <= tbl_word[15:0];
            sec_mem[tbl_idx] <= tbl_word[31:16];
        end
    end

    assign s_axi_awready    = !aw_reg;
    assign s_axi_wready     = !w_reg;
    assign s_axi_bvalid     = b_reg;
    assign s_axi_bresp      = br_reg;
    assign s_axi_arready    = !r_reg;
    assign s_axi_rvalid     = r_reg;
    assign s_axi_rdata      = rd_reg;
    assign s_axi_rresp      = rr_reg;
    assign program_setpoint = sp_reg;
    assign nv_write         = nv_reg;
endmodule
`default_nettype wire

// File: tb_setpoint_program_sequencer.sv
// Purpose: self-checking bench for the set-point sequencer
// Assumes: zero-second steps only, one tick is 40e6 cycles
// Notes:   every bus wait is bounded by the cycle watchdog
`default_nettype none
module tb_setpoint_program_sequencer
    import sps_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk          = 1'h0;
    logic        aresetn       = 1'h0;
    logic        ce            = 1'h1;
    logic        is_controller = 1'h1;
    logic [7:0]  s_axi_awaddr  = 8'h00;
    logic        s_axi_awvalid = 1'h0;
    logic [31:0] s_axi_wdata   = 32'h0;
    logic [3:0]  s_axi_wstrb   = 4'hf;
    logic        s_axi_wvalid  = 1'h0;
    logic        s_axi_bready  = 1'h0;
    logic [7:0]  s_axi_araddr  = 8'h00;
    logic        s_axi_arvalid = 1'h0;
    logic        s_axi_rready  = 1'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, nv_write;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [15:0] program_setpoint;
    int          failures, n_compared, cycles, nv_seen;

    always #12.5 aclk = ~aclk;

    sps_top dut_u (.aclk, .aresetn, .ce, .is_controller, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .program_setpoint, .nv_write);
    sps_flow_partner fc_u (.aclk, .aresetn, .program_setpoint);

    always @(posedge aclk) begin
        if (nv_write && ce) nv_seen++;
    end

    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        if (failures == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    // ready is raised only after valid shows, so the slave must hold its answer
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'h1;
        end while (!(s_axi_bvalid && s_axi_bready));
        chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
        s_axi_bready <= 1'h0;
        @(posedge aclk);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'h1;
        end while (!(s_axi_rvalid && s_axi_rready));
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
        @(posedge aclk);
    endtask

    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0]  r;
        rd(a, d, r);
        chk(nm, e, d);
        chk("rresp", {30'h0, er}, {30'h0, r});
    endtask

    task automatic wait_state(input logic [1:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        d = 32'h0;
        repeat (40) begin
            rd(OFF_STATUS, d, r);
            chk("rresp", {30'h0, RESP_OKAY}, {30'h0, r});
            if (d[1:0] === e) break;
        end
        chk("state", {30'h0, e}, {30'h0, d[1:0]});
    endtask

    task automatic t_reset();
        rdc("ctrl", OFF_CTRL, 32'h0, RESP_OKAY);
        rdc("mask", OFF_MASK, 32'h0000ffff, RESP_OKAY);
        chk("setpoint", 32'h0, {16'h0, program_setpoint});
        wait_state(2'h0);
    endtask

    task automatic t_store();
        int n0;
        n0 = nv_seen;
        wr(OFF_MASK, 32'h00005a5a, RESP_OKAY);
        rdc("mask", OFF_MASK, 32'h00005a5a, RESP_OKAY);
        wr(OFF_TABLE + 8'h3c, 32'h000702ee, RESP_OKAY);
        rdc("step15", OFF_TABLE + 8'h3c, 32'h000702ee, RESP_OKAY);
        wr(8'h20, 32'h1, RESP_SLVERR);
        rdc("unmapped", 8'h20, 32'h0, RESP_SLVERR);
        chk("nv count", n0 + 2, nv_seen);
    endtask

    task automatic t_run();
        int n0;
        int stp[3] = '{2, 5, 9};
        n0 = nv_seen;
        for (int i = 0; i < 16; i++)
            wr(OFF_TABLE + 8'(4 * i), {16'h0, 16'(100 + 10 * i)}, RESP_OKAY);
        wr(OFF_MASK, 32'h00000224, RESP_OKAY);
        chk("nv count", n0 + 17, nv_seen);
        fc_u.seen.delete();
        wr(OFF_CTRL, 32'h00000009, RESP_OKAY);
        wait_state(2'h3);
        chk("log size", 32'h3, fc_u.seen.size());
        for (int i = 0; i < 3; i++)
            chk("step log", 100 + 10 * stp[i], {16'h0, fc_u.seen[i]});
        wr(OFF_CTRL, 32'h0, RESP_OKAY);
        wait_state(2'h0);
        chk("held point", 32'h000000be, {16'h0, program_setpoint});
    endtask

    task automatic t_loop();
        wr(OFF_MASK, 32'h00008001, RESP_OKAY);
        fc_u.seen.delete();
        wr(OFF_CTRL, 32'h0000000b, RESP_OKAY);
        repeat (60) @(posedge aclk);
        for (int i = 0; i < 4; i++)
            chk("loop log", (i % 2) ? 250 : 100, {16'h0, fc_u.seen[i]});
        wr(OFF_CTRL, 32'h00000007, RESP_OKAY);
        // a step may still land while the pause write completes
        repeat (2) @(posedge aclk);
        fc_u.seen.delete();
        repeat (20) @(posedge aclk);
        chk("paused log", 32'h0, fc_u.seen.size());
        wr(OFF_CTRL, 32'h00000001, RESP_OKAY);
        wait_state(2'h3);
        chk("last point", 32'h000000fa, {16'h0, program_setpoint});
    endtask

    // start bit is cleared again before the function returns to controller
    task automatic t_guard();
        wr(OFF_CTRL, 32'h00000008, RESP_OKAY);
        repeat (20) @(posedge aclk);
        wait_state(2'h0);
        chk("disabled point", 32'h000000fa, {16'h0, program_setpoint});
        is_controller <= 1'h0;
        wr(OFF_CTRL, 32'h00000009, RESP_OKAY);
        repeat (30) @(posedge aclk);
        wait_state(2'h0);
        chk("monitor point", 32'h000000fa, {16'h0, program_setpoint});
        ce <= 1'h0;
        repeat (6) @(posedge aclk);
        ce <= 1'h1;
        wr(OFF_CTRL, 32'h0, RESP_OKAY);
        is_controller <= 1'h1;
        repeat (4) @(posedge aclk);
    endtask

    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        t_reset();
        t_store();
        t_run();
        t_loop();
        t_guard();
        print_verdict();
    end
endmodule
`default_nettype wire
